// file: rtl/dccd_cfg.svh
/*
 Register map constants for the DAC clamp and diagnostic configuration bank.
 Assumes inclusion by bare name from the design files.
*/
`ifndef DCCD_CFG_SVH
`define DCCD_CFG_SVH

// Byte addresses printed are not all word aligned: indices, byte address = 4 * index
`define DCCD_IDX_FB_COEF 32'h40000030
`define DCCD_IDX_NORM_LOW 32'h40000032
`define DCCD_IDX_NORM_HIGH 32'h40000034
`define DCCD_IDX_CLAMP_LOW 32'h40000036
`define DCCD_IDX_CLAMP_HIGH 32'h40000038
`define DCCD_IDX_DIAG_EN 32'h4000003A
// Word offsets (low 8 address bits of 4 * index), plus own registers
`define DCCD_OFF_FB_COEF 8'hC0
`define DCCD_OFF_NORM_LOW 8'hC8
`define DCCD_OFF_NORM_HIGH 8'hD0
`define DCCD_OFF_CLAMP_LOW 8'hD8
`define DCCD_OFF_CLAMP_HIGH 8'hE0
`define DCCD_OFF_DIAG_EN 8'hE8
`define DCCD_OFF_FF2_COEF 8'h00
`define DCCD_OFF_CTRL 8'h04
`define DCCD_OFF_FAULT 8'h08
`define DCCD_OFF_STATUS 8'h0C
`define DCCD_OFF_MASK 8'h10
`define DCCD_OFF_DAC_OUT 8'h14
// Field positions
`define DCCD_CTRL_GLOBAL_DIAG 2
`define DCCD_DIAG_P_IN_OV 0
`define DCCD_DIAG_P_IN_UV 1
`define DCCD_DIAG_T_IN_OV 2
`define DCCD_DIAG_P_AMP_OV 4
`define DCCD_DIAG_P_AMP_UV 5
`define DCCD_DIAG_T_AMP_OV 6
`define DCCD_DIAG_T_AMP_UV 7
`define DCCD_ST_LOW 0
`define DCCD_ST_HIGH 1
`define DCCD_ST_FAULT 2
// Reset values
`define DCCD_RST_16 16'h0000
`define DCCD_RST_12 12'h000
`define DCCD_RST_8 8'h00

`endif

// file: rtl/dccd_pkg.sv
/*
 Types shared by the clamp bank modules.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package dccd_pkg;
	typedef logic [11:0] dccd_code_t;
	typedef enum logic [1:0] {DCCD_PASS, DCCD_LOW, DCCD_HIGH, DCCD_FAULT} dccd_sel_t;
endpackage

// file: rtl/dccd_clamp_if.sv
/*
 Interface between the register bank and the clamp stage.
 Assumes both ends share hclk.
*/
`timescale 1ns/10ps
interface dccd_clamp_if;
	dccd_pkg::dccd_code_t norm_low;
	dccd_pkg::dccd_code_t norm_high;
	dccd_pkg::dccd_code_t clamp_low;
	dccd_pkg::dccd_code_t clamp_high;
	logic [7:0] fault_msb;
	logic fault_sel;
	dccd_pkg::dccd_code_t raw_code;
	dccd_pkg::dccd_code_t out_code;
	dccd_pkg::dccd_sel_t sel;
	modport bank (output norm_low, output norm_high, output clamp_low, output clamp_high,
		output fault_msb, output fault_sel, output raw_code,
		input out_code, input sel);
	modport clamp (input norm_low, input norm_high, input clamp_low, input clamp_high,
		input fault_msb, input fault_sel, input raw_code,
		output out_code, output sel);
endinterface

// file: rtl/dccd_clamp.sv
/*
 Combinational clamp stage: picks fault, low clamp, high clamp or pass.
 Assumes the register bank drives thresholds and samples the result.
*/
`timescale 1ns/10ps
module dccd_clamp (
	dccd_clamp_if.clamp cif
);
	wire below_w;
	wire above_w;
	wire [15:0] fault_w;

	// Fault value keeps its low byte at zero, only the top of a 12-bit code survives
	assign fault_w = {cif.fault_msb, 8'h00};
	assign below_w = cif.raw_code < cif.norm_low;
	assign above_w = cif.raw_code > cif.norm_high;

	// Fault first, then low, then high; inside the range the code passes
	assign cif.sel = cif.fault_sel ? dccd_pkg::DCCD_FAULT :
		below_w ? dccd_pkg::DCCD_LOW :
		above_w ? dccd_pkg::DCCD_HIGH : dccd_pkg::DCCD_PASS;
	assign cif.out_code = cif.fault_sel ? fault_w[15:4] :
		below_w ? cif.clamp_low :
		above_w ? cif.clamp_high :
		cif.raw_code;
endmodule

// file: rtl/dccd_bank.sv
/*
 AHB-Lite register bank for the output clamp, filter coefficients and
 diagnostic enables, with a registered DAC code and a level interrupt.
 Assumes a single AHB-Lite master, word transfers only, and that the
 raw DAC code and fault flags come from logic on hclk.
*/
`timescale 1ns/10ps
`include "dccd_cfg.svh"

// How it works
// - Code below normal low threshold is replaced by the low clamp value.
// - Code above normal high threshold is replaced by the high clamp value.
// - Twelve-bit read/write low clamp value, reset zero.
// - Twelve-bit read/write high clamp value, reset zero.
// - Twelve-bit read/write normal low and high thresholds.
// - Global_diag_on bits 0,1 gate pressure input over/under checks; reset zero.
// - Global_diag_on bit 2 gates temperature input over check; reset zero.
// - Global_diag_on bits 4,5 gate pressure amp over/under checks.
// - Global_diag_on bits 6,7 gate temperature amp over/under checks.
// - Sixteen-bit read/write filter feedback coefficient, reset zero.
// - Sixteen-bit read/write second feed-forward coefficient, reset zero.
// - Global diagnostics bit gates every front-end check.
// - Detected fault with diagnostics on drives the fault value to DAC.
module dccd_bank (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [11:0] raw_dac_code,
	input wire logic [6:0] fault_raw,
	output logic [11:0] dac_code,
	output logic [15:0] lowpass_feedback_coef,
	output logic [15:0] lowpass_second_ff_coef,
	output logic [6:0] diag_check_en,
	output logic irq
);
	dccd_clamp_if cif ();

	logic [15:0] fb_q;
	logic [15:0] ff2_q;
	logic [11:0] nlow_q;
	logic [11:0] nhigh_q;
	logic [11:0] clow_q;
	logic [11:0] chigh_q;
	logic [7:0] diag_q;
	logic global_q;
	logic [7:0] fault_msb_q;
	logic [2:0] status_q;
	logic [2:0] mask_q;
	logic [11:0] dac_q;
	logic wr_pend_q;
	logic [7:0] wr_off_q;
	logic [31:0] rdata_q;

	wire addr_ok_w;
	wire [7:0] off_w;
	wire wr_go_w;
	wire rd_go_w;
	wire [6:0] chk_en_w;
	wire fault_w;
	wire [2:0] event_w;
	wire [2:0] st_clr_w;
	wire [31:0] rd_mux_w;

	// Only valid NONSEQ/SEQ transfers are decoded
	function automatic logic hit(input logic [7:0] off, input logic [7:0] want);
		hit = (off == want);
	endfunction

	assign off_w = haddr[7:0];
	assign addr_ok_w = hsel && hready && htrans[1];
	assign wr_go_w = addr_ok_w && hwrite;
	assign rd_go_w = addr_ok_w && !hwrite;

	// Bus always answers in zero wait states, OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;

	// Per-check enables, each gated by the global bit; diag_q bit 3 feeds no check
	assign chk_en_w[0] = global_q && diag_q[`DCCD_DIAG_P_IN_OV];
	assign chk_en_w[1] = global_q && diag_q[`DCCD_DIAG_P_IN_UV];
	assign chk_en_w[2] = global_q && diag_q[`DCCD_DIAG_T_IN_OV];
	assign chk_en_w[3] = global_q && diag_q[`DCCD_DIAG_P_AMP_OV];
	assign chk_en_w[4] = global_q && diag_q[`DCCD_DIAG_P_AMP_UV];
	assign chk_en_w[5] = global_q && diag_q[`DCCD_DIAG_T_AMP_OV];
	assign chk_en_w[6] = global_q && diag_q[`DCCD_DIAG_T_AMP_UV];
	assign diag_check_en = chk_en_w;
	assign fault_w = |(fault_raw & chk_en_w);

	// Clamp stage hookup
	assign cif.norm_low = nlow_q;
	assign cif.norm_high = nhigh_q;
	assign cif.clamp_low = clow_q;
	assign cif.clamp_high = chigh_q;
	assign cif.fault_msb = fault_msb_q;
	assign cif.fault_sel = fault_w;
	assign cif.raw_code = raw_dac_code;

	dccd_clamp u_clamp (
		.cif(cif.clamp)
	);

	// Events: low clamp, high clamp, fault substitution
	assign event_w[`DCCD_ST_LOW] = (cif.sel == dccd_pkg::DCCD_LOW);
	assign event_w[`DCCD_ST_HIGH] = (cif.sel == dccd_pkg::DCCD_HIGH);
	assign event_w[`DCCD_ST_FAULT] = (cif.sel == dccd_pkg::DCCD_FAULT);
	assign st_clr_w = (wr_pend_q && hit(wr_off_q, `DCCD_OFF_STATUS)) ? hwdata[2:0] : 3'h0;

	// Read mux, reserved bits read as zero, unmapped reads zero
	assign rd_mux_w =
		hit(off_w, `DCCD_OFF_FB_COEF) ? {16'h0000, fb_q} :
		hit(off_w, `DCCD_OFF_NORM_LOW) ? {20'h00000, nlow_q} :
		hit(off_w, `DCCD_OFF_NORM_HIGH) ? {20'h00000, nhigh_q} :
		hit(off_w, `DCCD_OFF_CLAMP_LOW) ? {20'h00000, clow_q} :
		hit(off_w, `DCCD_OFF_CLAMP_HIGH) ? {20'h00000, chigh_q} :
		hit(off_w, `DCCD_OFF_DIAG_EN) ? {24'h000000, diag_q} :
		hit(off_w, `DCCD_OFF_FF2_COEF) ? {16'h0000, ff2_q} :
		hit(off_w, `DCCD_OFF_CTRL) ? {29'h00000000, global_q, 2'h0} :
		hit(off_w, `DCCD_OFF_FAULT) ? {16'h0000, fault_msb_q, 8'h00} :
		hit(off_w, `DCCD_OFF_STATUS) ? {29'h00000000, status_q} :
		hit(off_w, `DCCD_OFF_MASK) ? {29'h00000000, mask_q} :
		hit(off_w, `DCCD_OFF_DAC_OUT) ? {20'h00000, dac_q} : 32'h00000000;

	// Address phase capture; write data lands one cycle later
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_off_q <= 8'h00;
			rdata_q <= 32'h00000000;
		end else begin
			wr_pend_q <= wr_go_w;
			wr_off_q <= off_w;
			if (rd_go_w) begin
				rdata_q <= rd_mux_w;
			end
		end
	end

	// Coefficient and threshold writes, narrow fields take the low bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fb_q <= `DCCD_RST_16;
			ff2_q <= `DCCD_RST_16;
			nlow_q <= `DCCD_RST_12;
			nhigh_q <= `DCCD_RST_12;
			clow_q <= `DCCD_RST_12;
			chigh_q <= `DCCD_RST_12;
		end else if (wr_pend_q) begin
			if (hit(wr_off_q, `DCCD_OFF_FB_COEF)) fb_q <= hwdata[15:0];
			if (hit(wr_off_q, `DCCD_OFF_FF2_COEF)) ff2_q <= hwdata[15:0];
			if (hit(wr_off_q, `DCCD_OFF_NORM_LOW)) nlow_q <= hwdata[11:0];
			if (hit(wr_off_q, `DCCD_OFF_NORM_HIGH)) nhigh_q <= hwdata[11:0];
			if (hit(wr_off_q, `DCCD_OFF_CLAMP_LOW)) clow_q <= hwdata[11:0];
			if (hit(wr_off_q, `DCCD_OFF_CLAMP_HIGH)) chigh_q <= hwdata[11:0];
		end
	end

	// Control, diag enables, fault value and mask
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			diag_q <= `DCCD_RST_8;
			global_q <= 1'b0;
			fault_msb_q <= `DCCD_RST_8;
			mask_q <= 3'h0;
		end else if (wr_pend_q) begin
			if (hit(wr_off_q, `DCCD_OFF_DIAG_EN)) diag_q <= hwdata[7:0];
			if (hit(wr_off_q, `DCCD_OFF_CTRL)) global_q <= hwdata[`DCCD_CTRL_GLOBAL_DIAG];
			if (hit(wr_off_q, `DCCD_OFF_FAULT)) fault_msb_q <= hwdata[15:8];
			if (hit(wr_off_q, `DCCD_OFF_MASK)) mask_q <= hwdata[2:0];
		end
	end

	// Sticky status: a new event wins over a same-cycle clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_q <= 3'h0;
		end else begin
			status_q <= (status_q & ~st_clr_w) | event_w;
		end
	end

	// DAC code registered so the output stays glitch free
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dac_q <= `DCCD_RST_12;
		end else begin
			dac_q <= cif.out_code;
		end
	end

	assign dac_code = dac_q;
	assign lowpass_feedback_coef = fb_q;
	assign lowpass_second_ff_coef = ff2_q;
	assign irq = |(status_q & mask_q);
endmodule

// file: bench/dccd_bank_sva.sv
/* Port checker for the clamp bank.
 Assumes one hclk domain, bound onto dccd_bank by name. */
`timescale 1ns/10ps
module dccd_bank_sva (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [11:0] raw_dac_code,
	input wire logic [6:0] fault_raw,
	input wire logic [11:0] dac_code,
	input wire logic [15:0] lowpass_feedback_coef,
	input wire logic [15:0] lowpass_second_ff_coef,
	input wire logic [6:0] diag_check_en,
	input wire logic irq
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Accepted transfers; a write lands two edges after its address phase
	wire wr_take = hsel && hready && htrans[1] && hwrite;
	wire rd_take = hsel && hready && htrans[1] && !hwrite;
	sequence s_wr_commit; $past(wr_take, 2); endsequence
	sequence s_calm;
		(!wr_take) [*2] ##1 (!wr_take && fault_raw == 7'h00)
			##1 (!wr_take && fault_raw == 7'h00 && $stable(raw_dac_code));
	endsequence
	property p_pass_hold; s_calm |=> $stable(dac_code); endproperty
	a_pass_hold: assert property (p_pass_hold) else $error("dac code moved, inputs steady");
	property p_fault_code; (|(fault_raw & diag_check_en)) |=> dac_code[3:0] == 4'h0; endproperty
	a_fault_code: assert property (p_fault_code) else $error("fault code low bits set");
	property p_rst_clean;
		$rose(hresetn) |-> dac_code == 12'h000 && irq == 1'b0 && diag_check_en == 7'h00
			&& lowpass_feedback_coef == 16'h0000 && lowpass_second_ff_coef == 16'h0000;
	endproperty
	a_rst_clean: assert property (p_rst_clean) else $error("state not clear at reset");
	property p_fb_cause; $changed(lowpass_feedback_coef) |-> s_wr_commit; endproperty
	a_fb_cause: assert property (p_fb_cause) else $error("feedback coef moved alone");
	property p_ff_cause; $changed(lowpass_second_ff_coef) |-> s_wr_commit; endproperty
	a_ff_cause: assert property (p_ff_cause) else $error("ff coef moved alone");
	property p_en_cause; $changed(diag_check_en) |-> s_wr_commit; endproperty
	a_en_cause: assert property (p_en_cause) else $error("check enables moved alone");
	property p_bus_okay; hreadyout && !hresp; endproperty
	a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or error");
	property p_rdata_hold; $changed(hrdata) |-> $past(rd_take); endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved alone");
endmodule
bind dccd_bank dccd_bank_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.raw_dac_code(raw_dac_code), .fault_raw(fault_raw), .dac_code(dac_code), .irq(irq),
	.lowpass_feedback_coef(lowpass_feedback_coef), .diag_check_en(diag_check_en),
	.lowpass_second_ff_coef(lowpass_second_ff_coef));

// file: bench/tb_top.sv
/* Self-checking bench for the clamp bank over AHB-Lite.
 Assumes the bank answers with zero wait states, hready looped back. */
`timescale 1ns/10ps
`include "dccd_cfg.svh"
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin fails++; $display("BAD %s expected %h seen %h", nm, ex, gt); end end
module tb_top;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [11:0] raw, dac_code;
	logic [6:0] fault_raw, chk_en;
	logic [15:0] fb_coef, ff_coef;
	integer fails, compares;
	logic [7:0] offs [7] = '{`DCCD_OFF_FB_COEF, `DCCD_OFF_NORM_LOW, `DCCD_OFF_NORM_HIGH,
		`DCCD_OFF_CLAMP_LOW, `DCCD_OFF_CLAMP_HIGH, `DCCD_OFF_DIAG_EN, `DCCD_OFF_FF2_COEF};
	logic [31:0] msks [7] = '{32'h0000FFFF, 32'h00000FFF, 32'h00000FFF, 32'h00000FFF,
		32'h00000FFF, 32'h000000FF, 32'h0000FFFF};
	int pos [7] = '{0, 1, 2, 4, 5, 6, 7};
	dccd_bank dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .raw_dac_code(raw), .fault_raw(fault_raw),
		.dac_code(dac_code), .lowpass_feedback_coef(fb_coef), .lowpass_second_ff_coef(ff_coef),
		.diag_check_en(chk_en), .irq(irq));
	task automatic wrap_up();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Bounded wait for hready; a stuck bus ends the run
	task automatic wait_ready();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 50) begin
				fails++;
				wrap_up();
			end
			@(posedge hclk);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] off, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h000000, off};
		htrans <= 2'b10;
		hwrite <= w;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask
	task automatic rchk(input string nm, input logic [7:0] off, input logic [31:0] ex);
		xfer(1'b0, off, 32'h00000000);
		`CHK(nm, ex, rd)
	endtask
	// Output is registered: one edge to launch, one to sample
	task automatic apply(input logic [11:0] r, input logic [11:0] ex);
		raw <= r;
		repeat (2) @(posedge hclk);
		`CHK("dac_code", ex, dac_code)
	endtask
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	initial begin
		#1000000;
		fails++;
		wrap_up();
	end
	initial begin
		{hresetn, hsel, hwrite, haddr, htrans, hwdata, raw, fault_raw, fails, compares} = '0;
		hsize = 3'b010;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// Reset values, then all-ones to expose each field width
		for (int i = 0; i < 7; i++) begin
			rchk("reset", offs[i], 32'h00000000);
			xfer(1'b1, offs[i], 32'hFFFFFFFF);
			rchk("width", offs[i], msks[i]);
		end
		`CHK("fb_coef", 16'hFFFF, fb_coef)
		`CHK("ff_coef", 16'hFFFF, ff_coef)
		xfer(1'b1, 8'hF0, 32'hFFFFFFFF);
		rchk("unmapped", 8'hF0, 32'h00000000);
		xfer(1'b1, `DCCD_OFF_NORM_LOW, 32'h00000100);
		xfer(1'b1, `DCCD_OFF_NORM_HIGH, 32'h00000E00);
		xfer(1'b1, `DCCD_OFF_CLAMP_LOW, 32'h000000AB);
		xfer(1'b1, `DCCD_OFF_CLAMP_HIGH, 32'h00000FCD);
		apply(12'h0FF, 12'h0AB);
		apply(12'h100, 12'h100);
		apply(12'hE00, 12'hE00);
		apply(12'hE01, 12'hFCD);
		// Global diag off: every fault ignored
		fault_raw <= 7'h7F;
		apply(12'h7FF, 12'h7FF);
		`CHK("chk_en", 7'h00, chk_en)
		xfer(1'b1, `DCCD_OFF_CTRL, 32'h00000004);
		xfer(1'b1, `DCCD_OFF_FAULT, 32'h00005A00);
		rchk("ctrl", `DCCD_OFF_CTRL, 32'h00000004);
		rchk("fault", `DCCD_OFF_FAULT, 32'h00005A00);
		// One enable at a time: only its own fault reaches the output
		for (int i = 0; i < 7; i++) begin
			xfer(1'b1, `DCCD_OFF_DIAG_EN, 32'h1 << pos[i]);
			fault_raw <= ~(7'h01 << i);
			apply(12'h7FF, 12'h7FF);
			`CHK("chk_en", 7'h01 << i, chk_en)
			fault_raw <= 7'h01 << i;
			apply(12'h7FF, 12'h5A0);
		end
		fault_raw <= 7'h00;
		apply(12'h7FF, 12'h7FF);
		xfer(1'b1, `DCCD_OFF_MASK, 32'h00000001);
		@(posedge hclk);
		`CHK("irq", 1'b1, irq)
		xfer(1'b1, `DCCD_OFF_STATUS, 32'h00000007);
		@(posedge hclk);
		`CHK("irq", 1'b0, irq)
		apply(12'h050, 12'h0AB);
		`CHK("irq", 1'b1, irq)
		rchk("dac_out", `DCCD_OFF_DAC_OUT, 32'h000000AB);
		xfer(1'b1, `DCCD_OFF_MASK, 32'h00000002);
		@(posedge hclk);
		`CHK("irq", 1'b0, irq)
		// Second reset in mid-run
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rchk("clamp_high", `DCCD_OFF_CLAMP_HIGH, 32'h00000000);
		`CHK("fb_coef", 16'h0000, fb_coef)
		wrap_up();
	end
endmodule
